// ### design/sfpm_flash_ctrl.sv
/*
 * Sectored flash program memory with self-programming port, serial
 * tool port, byte programming, sector/mass erase and read protection.
 * Assumes sys_clk 200 MHz; tool serial pins asynchronous to sys_clk.
 */
// Contract
// - 4K one sector, 8K two, larger three
// - Sectors 0,1 4KB at top; 0 F000-FFFF
// - Single sector erase leaves others intact
// - Program bytewise; erase whole array or sector
// - Self-programming mode forbids sector 0, mass erase and option programming
// - Tool modes reach all sectors and options
// - Protection blocks readout and flash writes
// - Unprotecting erases all memory first
// - Option bit enables/disables read protection
// - Attached tool takes serial pins from application
`include "sfpm_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module sfpm_flash_ctrl
    import sfpm_pkg::*;
#(
    parameter logic [1:0] SIZE_SEL = `SFPM_SIZE_16K
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic tool_attached,
    input wire logic board_tool_programming_mode,
    input wire logic prog_select_voltage,
    input wire logic prog_serial_clock,
    input wire logic prog_serial_data_in,
    output logic prog_serial_data_out,
    output logic prog_serial_data_oe,
    input wire logic app_req_valid,
    input wire sfpm_req_t app_req,
    output sfpm_resp_t app_resp,
    input wire logic [15:0] rd_addr,
    input wire logic rd_ext,
    output logic [7:0] rd_data,
    output logic app_pins_free,
    output logic readout_protected,
    output logic busy
);

    localparam int NBYTES = (SIZE_SEL == `SFPM_SIZE_4K) ? 4096 :
        (SIZE_SEL == `SFPM_SIZE_8K) ? 8192 : 16384;
    localparam logic [15:0] BASE = 16'(32'h10000 - NBYTES);
    localparam logic [1:0] NSECT = (SIZE_SEL == `SFPM_SIZE_4K) ? 2'h1 :
        (SIZE_SEL == `SFPM_SIZE_8K) ? 2'h2 : 2'h3;

    typedef enum logic [1:0] {
        SFPM_IDLE = 2'b00,
        SFPM_ERASE = 2'b01,
        SFPM_UNPROT = 2'b10
    } sfpm_state_t;

    logic [7:0] mem [NBYTES];
    logic [7:0] option_r;
    sfpm_state_t state_r;
    logic [13:0] erase_idx_r;
    logic [13:0] erase_end_r;
    logic [7:0] opt_pend_r;

    ////////////////////////////////////////////////////////////////////
    // Synchronisers for tool pins
    logic [1:0] sclk_sync_r;
    logic [1:0] sdat_sync_r;
    logic [1:0] att_sync_r;
    logic [1:0] mode_sync_r;
    logic [1:0] vpp_sync_r;
    logic sclk_prev_r;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sclk_sync_r <= 2'h0;
            sdat_sync_r <= 2'h0;
            att_sync_r <= 2'h0;
            mode_sync_r <= 2'h0;
            vpp_sync_r <= 2'h0;
            sclk_prev_r <= 1'b0;
        end else begin
            sclk_sync_r <= {sclk_sync_r[0], prog_serial_clock};
            sdat_sync_r <= {sdat_sync_r[0], prog_serial_data_in};
            att_sync_r <= {att_sync_r[0], tool_attached};
            mode_sync_r <= {mode_sync_r[0], board_tool_programming_mode};
            vpp_sync_r <= {vpp_sync_r[0], prog_select_voltage};
            sclk_prev_r <= sclk_sync_r[1];
        end
    end

    logic sclk_rise;
    logic tool_mode;
    assign sclk_rise = sclk_sync_r[1] & ~sclk_prev_r;
    // Tool modes valid only with programming voltage applied
    assign tool_mode = mode_sync_r[1] & vpp_sync_r[1];

    ////////////////////////////////////////////////////////////////////
    // Serial frame: 2-bit cmd, 16-bit addr, 8-bit data, msb first
    logic [25:0] shift_r;
    logic [5:0] bit_cnt_r;
    logic tool_frame_r;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            shift_r <= 26'h0;
            bit_cnt_r <= 6'h0;
            tool_frame_r <= 1'b0;
        end else begin
            tool_frame_r <= 1'b0;
            if (!tool_mode) begin
                bit_cnt_r <= 6'h0;
            end else if (sclk_rise) begin
                shift_r <= {shift_r[24:0], sdat_sync_r[1]};
                if (bit_cnt_r == `SFPM_LINK_FRAME_BITS - 6'd1) begin
                    bit_cnt_r <= 6'h0;
                    tool_frame_r <= 1'b1;
                end else begin
                    bit_cnt_r <= bit_cnt_r + 6'h1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Request select and sector decode
    sfpm_req_t req;
    logic req_valid;
    logic [1:0] req_sector;
    logic in_array;
    logic allowed;
    logic [13:0] req_off;

    always_comb begin
        req = tool_frame_r ? sfpm_req_t'(shift_r) : app_req;
        req_valid = tool_frame_r | (app_req_valid & ~tool_mode);
        in_array = req.addr >= BASE;
        req_off = 14'(req.addr - BASE);
        if (req.addr >= `SFPM_SECT0_BASE) begin
            req_sector = 2'h0;
        end else if (req.addr >= `SFPM_SECT1_BASE) begin
            req_sector = 2'h1;
        end else begin
            req_sector = 2'h2;
        end
        allowed = 1'b1;
        if (req.cmd != SFPM_CMD_MERASE_E && req.cmd != SFPM_CMD_OPTPROG_E &&
            (!in_array || req_sector >= NSECT)) begin
            allowed = 1'b0;
        end
        if (!tool_frame_r && (req.cmd == SFPM_CMD_OPTPROG_E ||
            req.cmd == SFPM_CMD_MERASE_E || req_sector == 2'h0)) begin
            allowed = 1'b0;
        end
        if (option_r[`SFPM_OPT_RDP_BIT] == 1'b0 &&
            req.cmd != SFPM_CMD_OPTPROG_E) begin
            allowed = 1'b0;
        end
        // Busy output lags the state by one cycle; honour both
        if (state_r != SFPM_IDLE || busy) begin
            allowed = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Erase sequencer and option programming
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_r <= SFPM_IDLE;
            erase_idx_r <= 14'h0;
            erase_end_r <= 14'h0;
            opt_pend_r <= `SFPM_OPT_RESET;
            app_resp <= '0;
        end else begin
            app_resp <= '0;
            unique case (state_r)
                SFPM_IDLE: begin
                    if (req_valid) begin
                        app_resp.done <= allowed;
                        app_resp.rejected <= ~allowed;
                        if (allowed && req.cmd == SFPM_CMD_SERASE_E) begin
                            // Sector 2 spans all below sector 1
                            unique case (req_sector)
                                2'h0: begin
                                    erase_idx_r <= 14'(`SFPM_SECT0_BASE - BASE);
                                    erase_end_r <= 14'(NBYTES - 1);
                                end
                                2'h1: begin
                                    erase_idx_r <= 14'(`SFPM_SECT1_BASE - BASE);
                                    erase_end_r <= 14'(`SFPM_SECT0_BASE - BASE - 16'h1);
                                end
                                2'h2: begin
                                    erase_idx_r <= 14'h0;
                                    erase_end_r <= 14'(`SFPM_SECT1_BASE - BASE - 16'h1);
                                end
                            endcase
                            state_r <= SFPM_ERASE;
                        end else if (allowed &&
                            req.cmd == SFPM_CMD_MERASE_E) begin
                            erase_idx_r <= 14'h0;
                            erase_end_r <= 14'(NBYTES - 1);
                            state_r <= SFPM_ERASE;
                        end else if (allowed &&
                            req.cmd == SFPM_CMD_OPTPROG_E &&
                            option_r[`SFPM_OPT_RDP_BIT] == 1'b0 &&
                            req.data[`SFPM_OPT_RDP_BIT] == 1'b1) begin
                            opt_pend_r <= req.data;
                            erase_idx_r <= 14'h0;
                            erase_end_r <= 14'(NBYTES - 1);
                            state_r <= SFPM_UNPROT;
                        end
                    end
                end
                SFPM_ERASE, SFPM_UNPROT: begin
                    // Requests arriving mid-erase are answered, not lost
                    app_resp.rejected <= req_valid;
                    if (erase_idx_r == erase_end_r) begin
                        state_r <= SFPM_IDLE;
                    end else begin
                        erase_idx_r <= erase_idx_r + 14'h1;
                    end
                end
                default: state_r <= SFPM_IDLE;
            endcase
        end
    end

    // Option byte; protection active when bit is zero
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            option_r <= `SFPM_OPT_RESET;
        end else if (state_r == SFPM_UNPROT && erase_idx_r == erase_end_r) begin
            option_r <= opt_pend_r;
        end else if (state_r == SFPM_IDLE && req_valid && allowed &&
            req.cmd == SFPM_CMD_OPTPROG_E &&
            !(option_r[`SFPM_OPT_RDP_BIT] == 1'b0 &&
            req.data[`SFPM_OPT_RDP_BIT] == 1'b1)) begin
            option_r <= req.data & option_r;
        end
    end

    // Array: byte program clears bits, erase sets to ff
    always_ff @(posedge sys_clk) begin
        if (state_r != SFPM_IDLE) begin
            mem[erase_idx_r] <= `SFPM_ERASED_BYTE;
        end else if (req_valid && allowed && req.cmd == SFPM_CMD_PROG_E) begin
            mem[req_off] <= mem[req_off] & req.data;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read path and status outputs
    logic [13:0] rd_off;
    assign rd_off = 14'(rd_addr - BASE);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rd_data <= 8'h00;
            readout_protected <= 1'b0;
            busy <= 1'b0;
            app_pins_free <= 1'b1;
            prog_serial_data_out <= 1'b0;
            prog_serial_data_oe <= 1'b0;
        end else begin
            if (rd_addr < BASE) begin
                rd_data <= 8'h00;
            end else if (rd_ext && option_r[`SFPM_OPT_RDP_BIT] == 1'b0) begin
                rd_data <= 8'h00;
            end else begin
                rd_data <= mem[rd_off];
            end
            readout_protected <= ~option_r[`SFPM_OPT_RDP_BIT];
            busy <= state_r != SFPM_IDLE;
            app_pins_free <= ~att_sync_r[1];
            prog_serial_data_out <= 1'b0;
            prog_serial_data_oe <= 1'b0;
        end
    end

endmodule : sfpm_flash_ctrl

`default_nettype wire

// ### design/sfpm_defs.svh
/*
 * Constants of the sectored flash program memory controller:
 * sector map, array sizes, link timing and command codes.
 * Assumes inclusion by bare name from design files.
 */
`ifndef SFPM_DEFS_SVH
`define SFPM_DEFS_SVH

`define SFPM_ADDR_W 16
`define SFPM_SECT_SIZE 16'h1000
`define SFPM_SECT0_BASE 16'hf000
`define SFPM_SECT1_BASE 16'he000
`define SFPM_SIZE_4K 2'h0
`define SFPM_SIZE_8K 2'h1
`define SFPM_SIZE_16K 2'h2
`define SFPM_ERASED_BYTE 8'hff
`define SFPM_OPT_ERASED 8'hff
`define SFPM_OPT_RDP_BIT 0
`define SFPM_OPT_RESET 8'hff
`define SFPM_CMD_PROG 2'h0
`define SFPM_CMD_SECT_ERASE 2'h1
`define SFPM_CMD_MASS_ERASE 2'h2
`define SFPM_CMD_OPT_PROG 2'h3
`define SFPM_LINK_FRAME_BITS 6'd26
`define SFPM_ERASE_CYC 8'd16

`endif

// ### design/sfpm_pkg.sv
/*
 * Types of the sectored flash program memory controller.
 * Assumes sfpm_defs.svh is compiled alongside.
 */
package sfpm_pkg;

    typedef enum logic [1:0] {
        SFPM_CMD_PROG_E = 2'h0,
        SFPM_CMD_SERASE_E = 2'h1,
        SFPM_CMD_MERASE_E = 2'h2,
        SFPM_CMD_OPTPROG_E = 2'h3
    } sfpm_cmd_t;

    typedef struct packed {
        sfpm_cmd_t cmd;
        logic [15:0] addr;
        logic [7:0] data;
    } sfpm_req_t;

    typedef struct packed {
        logic done;
        logic rejected;
    } sfpm_resp_t;

endpackage : sfpm_pkg

// ### bench/sfpm_checker.sv
/* Port checker for the flash controller.
   Assumes a bind onto sfpm_flash_ctrl from the bench top. */
`timescale 1ns/10ps
`default_nettype none
module sfpm_checker
    import sfpm_pkg::*;
#(
    parameter logic [1:0] SIZE_SEL = 2'h2
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic tool_attached,
    input wire logic prog_select_voltage,
    input wire logic app_req_valid,
    input wire sfpm_req_t app_req,
    input wire sfpm_resp_t app_resp,
    input wire logic rd_ext,
    input wire logic [7:0] rd_data,
    input wire logic app_pins_free,
    input wire logic readout_protected,
    input wire logic busy
);
    localparam logic [15:0] BASE = (SIZE_SEL == 2'h0) ? 16'hf000 :
        (SIZE_SEL == 2'h1) ? 16'he000 : 16'hc000;
    logic [2:0] low_cnt_r;
    logic app_rq;
    ////////////////////////////////////////
    // Tool mode surely off after four quiet cycles
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            low_cnt_r <= 3'h0;
        end else if (prog_select_voltage) begin
            low_cnt_r <= 3'h0;
        end else if (low_cnt_r != 3'h4) begin
            low_cnt_r <= low_cnt_r + 3'h1;
        end
    end
    assign app_rq = app_req_valid && (low_cnt_r == 3'h4);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    AST_PINS_TAKEN: assert property (
        $rose(tool_attached) |-> ##[1:4] !app_pins_free)
        else $error("pins not withdrawn");
    AST_RESP_ONE: assert property (!(app_resp.done && app_resp.rejected))
        else $error("done and rejected together");
    AST_SECT0_APP: assert property (
        app_rq && app_req.addr[15:12] == 4'hf |=> app_resp.rejected)
        else $error("sector 0 reached by application");
    AST_MASS_APP: assert property (
        app_rq && app_req.cmd == SFPM_CMD_MERASE_E |=> app_resp.rejected)
        else $error("mass erase by application");
    AST_BELOW: assert property (
        app_rq && app_req.addr < BASE |=> app_resp.rejected)
        else $error("absent sector accepted");
    AST_PROT_WR: assert property (
        app_rq && readout_protected |=> app_resp.rejected)
        else $error("write while protected");
    // Flag and read data are both one cycle behind the option bit
    AST_EXT_RD: assert property (rd_ext ##1 readout_protected |-> rd_data == 8'h00)
        else $error("protected data read out");
    AST_BUSY_REJ: assert property (app_rq && busy |=> app_resp.rejected)
        else $error("request taken while busy");
    AST_ERASE_BUSY: assert property (app_resp.done && $past(app_rq) &&
        $past(app_req.cmd) == SFPM_CMD_SERASE_E |=> busy [*8])
        else $error("sector erase not busy");
endmodule : sfpm_checker
`default_nettype wire

// ### bench/sfpm_tool_model.sv
/* Programming tool model: serial frames, reset line held.
   Assumes the bench calls send between frames only. */
`timescale 1ns/10ps
`default_nettype none
module sfpm_tool_model (
    output logic prog_serial_clock,
    output logic prog_serial_data,
    output logic tool_rst
);
    initial begin
        prog_serial_clock = 1'b0;
        prog_serial_data = 1'b0;
        tool_rst = 1'b0;
    end
    // Msb first, 160 ns bit; clock idles low, data inverts after a frame
    task send(input logic [25:0] frame);
        // Lead time lets the previous frame's tail settle first
        #83;
        for (int i = 25; i >= 0; i--) begin
            prog_serial_data = frame[i];
            #80 prog_serial_clock = 1'b1;
            if (i > 0)
                #80 prog_serial_clock = 1'b0;
        end
        fork
            #80 begin
                prog_serial_clock = 1'b0;
                prog_serial_data = ~frame[0];
            end
        join_none
    endtask : send
endmodule : sfpm_tool_model
`default_nettype wire

// ### bench/sfpm_flash_ctrl_tb.sv
/* Self-checking bench of the flash controller.
   Assumes sfpm_pkg, the tool model and the checker are compiled first. */
`timescale 1ns/10ps
`default_nettype none
module sfpm_flash_ctrl_tb;
    import sfpm_pkg::*;
    logic sys_clk, rst_r, tool_rst, rst, attach_r, mode_r, volt_r, sclk, sdat;
    logic valid_r, ext_r, pins_free, prot, busy, sdo, soe;
    sfpm_req_t req_r;
    sfpm_resp_t resp;
    logic [15:0] addr_r;
    logic [7:0] rd_data, r;
    int errors, checked;
    assign rst = rst_r | tool_rst;
    sfpm_tool_model tool (.prog_serial_clock(sclk), .prog_serial_data(sdat), .tool_rst(tool_rst));
    sfpm_flash_ctrl dut (.sys_clk(sys_clk), .rst(rst), .tool_attached(attach_r),
        .board_tool_programming_mode(mode_r), .prog_select_voltage(volt_r),
        .prog_serial_clock(sclk), .prog_serial_data_in(sdat), .prog_serial_data_out(sdo),
        .prog_serial_data_oe(soe), .app_req_valid(valid_r), .app_req(req_r), .app_resp(resp),
        .rd_addr(addr_r), .rd_ext(ext_r), .rd_data(rd_data), .app_pins_free(pins_free),
        .readout_protected(prot), .busy(busy));
    task check(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task summarize;
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize
    task automatic wait_bit(ref logic s, input logic v, input int lim);
        int n = 0;
        while (s !== v) begin
            if (++n > lim) begin
                errors++;
                $display("mismatch at %0t: wait ran out", $time);
                summarize();
            end
            @(posedge sys_clk);
            #1;
        end
    endtask : wait_bit
    ////////////////////////////////////////
    // Bus cycles and reads
    task automatic answer(input int lim);
        int n = 0;
        while (resp.done !== 1'b1 && resp.rejected !== 1'b1) begin
            if (++n > lim) begin
                errors++;
                $display("mismatch at %0t: no answer", $time);
                summarize();
            end
            @(posedge sys_clk);
            #1;
        end
        r = {6'h00, resp};
    endtask : answer
    task app_op(input sfpm_cmd_t c, input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        valid_r <= 1'b1;
        req_r <= {c, a, d};
        @(posedge sys_clk);
        valid_r <= 1'b0;
        #1;
        answer(3);
    endtask : app_op
    task tool_op(input sfpm_cmd_t c, input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        tool.send({c, a, d});
        answer(20000);
    endtask : tool_op
    task rd(input logic [15:0] a, input logic e, input logic [7:0] exp);
        @(posedge sys_clk);
        addr_r <= a;
        ext_r <= e;
        @(posedge sys_clk);
        #1;
        check(rd_data, exp);
    endtask : rd
    task tool_mode(input logic on);
        @(posedge sys_clk);
        attach_r <= on;
        mode_r <= on;
        volt_r <= on;
        wait_bit(pins_free, ~on, 10);
        check(pins_free, !on);
    endtask : tool_mode
    ////////////////////////////////////////
    task t_tool;
        tool_mode(1'b1);
        tool_op(SFPM_CMD_MERASE_E, 16'h0000, 8'h00);
        check(r, 8'h02);
        check({6'h00, sdo, soe}, 8'h00);
        wait_bit(busy, 1'b1, 5);
        wait_bit(busy, 1'b0, 20000);
        tool_op(SFPM_CMD_PROG_E, 16'hf000, 8'ha5);
        check(r, 8'h02);
        tool_op(SFPM_CMD_PROG_E, 16'hf000, 8'h0f);
        rd(16'hf000, 1'b0, 8'h05);
        $display("tool session test done");
    endtask : t_tool
    task t_protect;
        tool_op(SFPM_CMD_OPTPROG_E, 16'h0000, 8'hfe);
        wait_bit(prot, 1'b1, 5);
        check(prot, 1'b1);
        rd(16'hf000, 1'b1, 8'h00);
        tool_mode(1'b0);
        app_op(SFPM_CMD_PROG_E, 16'he000, 8'h00);
        check(r, 8'h01);
        tool_mode(1'b1);
        tool_op(SFPM_CMD_OPTPROG_E, 16'h0000, 8'hff);
        wait_bit(busy, 1'b1, 5);
        wait_bit(busy, 1'b0, 20000);
        wait_bit(prot, 1'b0, 20000);
        check(prot, 1'b0);
        rd(16'hf000, 1'b1, 8'hff);
        tool_mode(1'b0);
        $display("protection test done");
    endtask : t_protect
    task t_app;
        app_op(SFPM_CMD_PROG_E, 16'he000, 8'h5a);
        rd(16'he000, 1'b0, 8'h5a);
        app_op(SFPM_CMD_PROG_E, 16'hf010, 8'h00);
        check(r, 8'h01);
        app_op(SFPM_CMD_MERASE_E, 16'hc000, 8'h00);
        check(r, 8'h01);
        app_op(SFPM_CMD_OPTPROG_E, 16'h0000, 8'hfe);
        check(r, 8'h01);
        app_op(SFPM_CMD_PROG_E, 16'h1000, 8'h00);
        check(r, 8'h01);
        app_op(SFPM_CMD_PROG_E, 16'hc000, 8'h0f);
        check(r, 8'h02);
        app_op(SFPM_CMD_SERASE_E, 16'he123, 8'h00);
        check(r, 8'h02);
        app_op(SFPM_CMD_PROG_E, 16'hc001, 8'h00);
        check(r, 8'h01);
        wait_bit(busy, 1'b0, 5000);
        rd(16'he000, 1'b0, 8'hff);
        rd(16'hc000, 1'b0, 8'h0f);
        app_op(SFPM_CMD_PROG_E, 16'hd800, 8'h00);
        app_op(SFPM_CMD_SERASE_E, 16'hc000, 8'h00);
        check(r, 8'h02);
        wait_bit(busy, 1'b1, 5);
        wait_bit(busy, 1'b0, 9000);
        rd(16'hd800, 1'b0, 8'hff);
        $display("application test done");
    endtask : t_app
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    initial begin
        {rst_r, attach_r, mode_r, volt_r, valid_r, ext_r} = 6'h20;
        req_r = '0;
        addr_r = 16'h0000;
        errors = 0;
        checked = 0;
        repeat (3) @(posedge sys_clk);
        rst_r <= 1'b0;
        t_tool();
        t_protect();
        t_app();
        summarize();
    end
endmodule : sfpm_flash_ctrl_tb
bind sfpm_flash_ctrl sfpm_checker #(.SIZE_SEL(SIZE_SEL)) chk (.sys_clk(sys_clk), .rst(rst),
    .tool_attached(tool_attached), .prog_select_voltage(prog_select_voltage),
    .app_req_valid(app_req_valid), .app_req(app_req), .app_resp(app_resp), .rd_ext(rd_ext),
    .rd_data(rd_data), .app_pins_free(app_pins_free), .readout_protected(readout_protected),
    .busy(busy));
`default_nettype wire
